// >>> hw/instr_decode_defines.svh
// Field layout, encodings and fixed addresses of the instruction classifier.
// Assumes inclusion by bare name; definitions only.
`ifndef INSTR_DECODE_DEFINES_SVH
`define INSTR_DECODE_DEFINES_SVH

`define WORD_W       16
`define MAG_W        14
`define ADDR_W       12
`define ORD_W        3
`define QC_W         2
`define CHOP_W       3
`define KEY_W        5
`define CSEL_W       5

`define ORD_HI       14
`define ORD_LO       12
`define ADDR_HI      11
`define QC_HI        11
`define QC_LO        10
`define CHOP_HI      11
`define CHOP_LO      9
`define CHAN_HI      8

`define NUM_COUNTERS 5'h1d
`define CNT_BASE     12'h024
`define KEY_VEC      12'h810
`define RUPT_VEC     12'h800

`define SPC_RELINT   12'h003
`define SPC_INHINT   12'h004
`define SPC_EXTEND   12'h006
`define SPC_TESTRUPT 12'h00e
`define SPC_RESUME   12'h00f
`define SPC_SHR      12'h010
`define SPC_CYR      12'h011
`define SPC_SHL      12'h012
`define SPC_CYL      12'h013

`define OP_TC        3'h0
`define OP_CCS       3'h1
`define OP_MOD       3'h2
`define OP_CA        3'h3
`define OP_XCHS      3'h4
`define OP_ADS       3'h5
`define OP_AD        3'h6
`define OP_MASK      3'h7

`define XOP_CHAN     3'h0
`define XOP_DIV      3'h1
`define XOP_MSU      3'h2
`define XOP_DCA      3'h3
`define XOP_INC      3'h4
`define XOP_SU       3'h5
`define XOP_MP       3'h6
`define XOP_BR       3'h7

`define QC_XCH       2'h0
`define QC_DXCH      2'h1
`define QC_TS        2'h2
`define QC_DAS       2'h1
`define QC_INCR      2'h0
`define QC_AUG       2'h1

`define CHO_READ     3'h0
`define CHO_RAND     3'h1
`define CHO_ROR      3'h2
`define CHO_RXOR     3'h3
`define CHO_WRITE    3'h4
`define CHO_WAND     3'h5
`define CHO_WOR      3'h6

`endif

// >>> hw/instr_decode_pkg.sv
// Types shared by the instruction classifier and its bench.
// Assumes nothing beyond a SystemVerilog compiler.
package instr_decode_pkg;

	typedef enum logic [2:0] {
		CL_BASIC, CL_EXTRA, CL_CHANNEL, CL_SPECIAL, CL_INTERRUPT, CL_COUNTER
	} class_t;

	typedef enum logic [5:0] {
		OP_NONE, TRANSFER, DECIDE, MODIFY, COPY, COPY_DBL, EXCHANGE, EXCHANGE_DBL,
		STORE, ADD, ADD_STORE, ADD_STORE_DBL, AND_OP, SUB, SUB_TWOS, MUL, DIV,
		BRANCH, INC_SIGNED, INC_MAG, DEC_MAG, CH_READ, CH_READ_AND, CH_READ_OR,
		CH_READ_XOR, CH_WRITE, CH_WRITE_AND, CH_WRITE_OR, SP_EXTEND, SP_INHIBIT,
		SP_RELEASE, SP_RESUME, SP_SHIFT_R, SP_ROT_R, SP_SHIFT_L, SP_ROT_L,
		RUPT_KEY, RUPT_GEN, CNT_INC1, CNT_DEC1, CNT_INC2, CNT_DEC2
	} op_t;

	typedef enum logic [1:0] {
		CNT_ONES_INC, CNT_ONES_DEC, CNT_TWOS_INC, CNT_TWOS_DEC
	} cnt_op_t;

	typedef enum logic {ST_RUN, ST_STOP} state_t;

endpackage

// >>> hw/sync_2ff.sv
// Two-stage synchroniser for pin-level inputs.
// Assumes a multi-bit input is held stable across its sampling window.
`timescale 1ns/1ps
module sync_2ff #(
	parameter int W = 1
) (
	input  wire logic         core_clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] held;
	} sync_state_t;

	sync_state_t s_reg;
	sync_state_t s_next;

	// First stage feeds only the second stage
	always_comb begin
		s_next.meta = d;
		s_next.held = s_reg.meta;
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign q = s_reg.held;
endmodule // sync_2ff

// >>> hw/instr_class_decode.sv
// Instruction classification, priority forcing and keypress entry.
// Assumes memory presents words in stored order and priority logic on core_clk.
`timescale 1ns/1ps
`include "instr_decode_defines.svh"
module instr_class_decode
	import instr_decode_pkg::*;
(
	input  wire logic                core_clk,
	input  wire logic                rst,
	input  wire logic                instr_valid,
	output logic                     instr_ready,
	input  wire logic [`WORD_W-1:0]  instr_word,
	input  wire logic                counter_req,
	input  wire logic [`CSEL_W-1:0]  counter_sel,
	input  wire cnt_op_t             counter_op,
	output logic                     counter_ack,
	input  wire logic                rupt_req,
	input  wire logic                key_strobe_pin,
	input  wire logic [`KEY_W-1:0]   keycode_pin,
	input  wire logic                monitor_stop_pin,
	output logic                     disp_valid,
	input  wire logic                disp_ready,
	output class_t                   disp_class,
	output op_t                      disp_op,
	output logic [`ADDR_W-1:0]       disp_addr,
	output logic                     disp_chan_space,
	output logic                     disp_double,
	output logic                     extend_mode,
	output logic                     inhibit_mode,
	output logic                     rupt_active,
	output logic [`KEY_W-1:0]        key_channel,
	output logic                     key_signal,
	output logic                     monitor_stop
);
	localparam int AW = `ADDR_W;

	typedef struct packed {
		state_t              fsm;
		logic                extend;
		logic                inhibit;
		logic                rupt_active;
		logic                key_pending;
		logic                key_prev;
		logic [`KEY_W-1:0]   key_chan;
		logic                key_pulse;
		logic                disp_valid;
		class_t              disp_class;
		op_t                 disp_op;
		logic [`ADDR_W-1:0]  disp_addr;
		logic                disp_chan;
		logic                disp_double;
	} state_s_t;

	state_s_t s_reg;
	state_s_t s_next;

	logic               key_s;
	logic [`KEY_W-1:0]  keycode_s;
	logic               stop_s;
	logic               slot_free;
	logic               rupt_ok;
	logic               forced;
	logic               key_rise;
	logic               take_key;
	logic               take_gen;
	logic               take_ins;
	logic               cnt_ok;
	class_t             dcl;
	op_t                dop;
	logic [`ADDR_W-1:0] dadr;
	logic               dchan;
	logic [`ORD_W-1:0]  ord;
	logic [`ADDR_W-1:0] adr;
	logic [`QC_W-1:0]   qc;
	logic [`CHOP_W-1:0] chop;

	////////////////////////////////////////////////////////////////////////////////
	// Pin inputs

	sync_2ff #(.W(1)) u_key_sync (
		.core_clk (core_clk),
		.rst      (rst),
		.d        (key_strobe_pin),
		.q        (key_s)
	);

	sync_2ff #(.W(`KEY_W)) u_code_sync (
		.core_clk (core_clk),
		.rst      (rst),
		.d        (keycode_pin),
		.q        (keycode_s)
	);

	sync_2ff #(.W(1)) u_stop_sync (
		.core_clk (core_clk),
		.rst      (rst),
		.d        (monitor_stop_pin),
		.q        (stop_s)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Decode and dispatch

	assign ord  = instr_word[`ORD_HI:`ORD_LO];
	assign adr  = instr_word[`ADDR_HI:0];
	assign qc   = instr_word[`QC_HI:`QC_LO];
	assign chop = instr_word[`CHOP_HI:`CHOP_LO];

	always_comb begin
		s_next = s_reg;
		dcl    = CL_BASIC;
		dop    = OP_NONE;
		dadr   = adr;
		dchan  = 1'b0;
		if (!s_reg.extend) begin
			case (ord)
				`OP_TC: begin
					// Special words are transfers to reserved addresses
					dcl = CL_SPECIAL;
					case (adr)
						`SPC_EXTEND:   dop = SP_EXTEND;
						`SPC_INHINT:   dop = SP_INHIBIT;
						`SPC_RELINT:   dop = SP_RELEASE;
						`SPC_RESUME:   dop = SP_RESUME;
						`SPC_SHR:      dop = SP_SHIFT_R;
						`SPC_CYR:      dop = SP_ROT_R;
						`SPC_SHL:      dop = SP_SHIFT_L;
						`SPC_CYL:      dop = SP_ROT_L;
						`SPC_TESTRUPT: begin
							dcl  = CL_INTERRUPT;
							dop  = RUPT_GEN;
							dadr = `RUPT_VEC;
						end
						default: begin
							dcl = CL_BASIC;
							dop = TRANSFER;
						end
					endcase
				end
				`OP_CCS:  dop = DECIDE;
				`OP_MOD:  dop = MODIFY;
				`OP_CA:   dop = COPY;
				`OP_XCHS: begin
					case (qc)
						`QC_XCH:  dop = EXCHANGE;
						`QC_DXCH: dop = EXCHANGE_DBL;
						`QC_TS:   dop = STORE;
						default:  dop = EXCHANGE;
					endcase
				end
				`OP_ADS:  dop = (qc == `QC_DAS) ? ADD_STORE_DBL : ADD_STORE;
				`OP_AD:   dop = ADD;
				`OP_MASK: dop = AND_OP;
				default:  dop = OP_NONE;
			endcase
		end else begin
			dcl = CL_EXTRA;
			case (ord)
				`XOP_CHAN: begin
					dcl   = CL_CHANNEL;
					dchan = 1'b1;
					dadr  = AW'(adr[`CHAN_HI:0]);
					case (chop)
						`CHO_READ:  dop = CH_READ;
						`CHO_RAND:  dop = CH_READ_AND;
						`CHO_ROR:   dop = CH_READ_OR;
						`CHO_RXOR:  dop = CH_READ_XOR;
						`CHO_WRITE: dop = CH_WRITE;
						`CHO_WAND:  dop = CH_WRITE_AND;
						`CHO_WOR:   dop = CH_WRITE_OR;
						default:    dop = CH_READ;
					endcase
				end
				`XOP_DIV: dop = DIV;
				`XOP_MSU: dop = SUB_TWOS;
				`XOP_DCA: dop = COPY_DBL;
				`XOP_INC: begin
					case (qc)
						`QC_INCR: dop = INC_SIGNED;
						`QC_AUG:  dop = INC_MAG;
						default:  dop = DEC_MAG;
					endcase
				end
				`XOP_SU:  dop = SUB;
				`XOP_MP:  dop = MUL;
				`XOP_BR:  dop = BRANCH;
				default:  dop = OP_NONE;
			endcase
		end

		case (s_reg.fsm)
			ST_RUN:  s_next.fsm = stop_s ? ST_STOP : ST_RUN;
			ST_STOP: s_next.fsm = stop_s ? ST_STOP : ST_RUN;
			default: s_next.fsm = ST_STOP;
		endcase

		slot_free = !s_reg.disp_valid || disp_ready;
		// No interrupt splits an extend pair or nests inside a service routine
		rupt_ok   = !s_reg.inhibit && !s_reg.extend && !s_reg.rupt_active;
		forced    = counter_req || (rupt_ok && (s_reg.key_pending || rupt_req));
		take_key  = slot_free && !counter_req && rupt_ok && s_reg.key_pending;
		take_gen  = slot_free && !counter_req && rupt_ok && !s_reg.key_pending
		            && rupt_req;
		instr_ready = slot_free && !forced && (s_reg.fsm == ST_RUN);
		take_ins  = instr_ready && instr_valid;
		counter_ack = slot_free && counter_req;
		cnt_ok    = counter_sel < `NUM_COUNTERS;
		key_rise  = key_s && !s_reg.key_prev;

		s_next.key_prev  = key_s;
		s_next.key_pulse = 1'b0;
		if (disp_ready) begin
			s_next.disp_valid = 1'b0;
		end

		if (counter_ack) begin
			// Out-of-range selects are taken and dropped
			s_next.disp_valid = cnt_ok;
			s_next.disp_class = CL_COUNTER;
			s_next.disp_addr  = `CNT_BASE + AW'(counter_sel);
			s_next.disp_chan  = 1'b0;
			s_next.disp_double = 1'b0;
			case (counter_op)
				CNT_ONES_INC: s_next.disp_op = CNT_INC1;
				CNT_ONES_DEC: s_next.disp_op = CNT_DEC1;
				CNT_TWOS_INC: s_next.disp_op = CNT_INC2;
				default:      s_next.disp_op = CNT_DEC2;
			endcase
		end else if (take_key || take_gen) begin
			s_next.disp_valid  = 1'b1;
			s_next.disp_class  = CL_INTERRUPT;
			s_next.disp_op     = take_key ? RUPT_KEY : RUPT_GEN;
			s_next.disp_addr   = take_key ? `KEY_VEC : `RUPT_VEC;
			s_next.disp_chan   = 1'b0;
			s_next.disp_double = 1'b0;
			s_next.rupt_active = 1'b1;
			if (take_key) begin
				s_next.key_pending = 1'b0;
			end
		end else if (take_ins) begin
			s_next.disp_valid  = 1'b1;
			s_next.disp_class  = dcl;
			s_next.disp_op     = dop;
			s_next.disp_addr   = dadr;
			s_next.disp_chan   = dchan;
			s_next.disp_double = (dop == COPY_DBL) || (dop == EXCHANGE_DBL)
			                     || (dop == ADD_STORE_DBL) || (dop == MUL)
			                     || (dop == DIV);
			s_next.extend = (dop == SP_EXTEND);
			if (dop == SP_INHIBIT) begin
				s_next.inhibit = 1'b1;
			end
			if (dop == SP_RELEASE) begin
				s_next.inhibit = 1'b0;
			end
			if ((dop == SP_RESUME) || (dop == RUPT_GEN)) begin
				s_next.rupt_active = (dop == RUPT_GEN);
			end
		end

		// Set after clear: a key in the dispatch cycle stays pending
		if (key_rise) begin
			s_next.key_pending = 1'b1;
			s_next.key_chan    = keycode_s;
			s_next.key_pulse   = 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			s_reg <= '{fsm: ST_RUN, disp_class: CL_BASIC, disp_op: OP_NONE, default: '0};
		end else begin
			s_reg <= s_next;
		end
	end

	assign disp_valid      = s_reg.disp_valid;
	assign disp_class      = s_reg.disp_class;
	assign disp_op         = s_reg.disp_op;
	assign disp_addr       = s_reg.disp_addr;
	assign disp_chan_space = s_reg.disp_chan;
	assign disp_double     = s_reg.disp_double;
	assign extend_mode     = s_reg.extend;
	assign inhibit_mode    = s_reg.inhibit;
	assign rupt_active     = s_reg.rupt_active;
	assign key_channel     = s_reg.key_chan;
	assign key_signal      = s_reg.key_pulse;
	assign monitor_stop    = (s_reg.fsm == ST_STOP);

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	a_key_capture: assert property (key_rise |=> key_signal && key_channel == $past(keycode_s))
		else $error("keycode not latched on keypress");
	a_key_vector: assert property (disp_valid && disp_op == RUPT_KEY |->
		disp_addr == `KEY_VEC && disp_class == CL_INTERRUPT)
		else $error("key service dispatched with wrong address");
	a_key_dispatch: assert property (take_key |=> disp_valid && disp_op == RUPT_KEY
		&& rupt_active)
		else $error("pending key not dispatched");
	a_forced_block: assert property (counter_req |-> !instr_ready)
		else $error("regular word accepted during forced instruction");
	a_stop_halt: assert property (stop_s ##1 stop_s |-> !instr_ready)
		else $error("program ran during monitor stop");
	a_extend_next: assert property (extend_mode && take_ins |->
		dcl != CL_BASIC && dcl != CL_SPECIAL ##1 !extend_mode)
		else $error("extend mode not applied to next word only");
	a_chan_space: assert property (disp_valid && disp_class == CL_CHANNEL |->
		disp_chan_space && disp_addr[`ADDR_HI:`CHAN_HI+1] == '0)
		else $error("channel op reached ordinary memory");
	a_cnt_addr: assert property (counter_ack && cnt_ok |=> disp_valid
		&& disp_class == CL_COUNTER && disp_addr == `CNT_BASE + AW'($past(counter_sel)))
		else $error("counter address wrong");
	a_stored_order: assert property (take_ins && dcl == CL_BASIC |=> disp_valid
		&& disp_addr == $past(adr))
		else $error("regular word not dispatched in order");
	a_inhibit_hold: assert property (inhibit_mode |-> !take_key && !take_gen)
		else $error("interrupt taken while inhibited");

	c_key_rupt:  cover property (take_key ##1 disp_valid);
	c_counter:   cover property (counter_ack && cnt_ok);
	c_ext_chan:  cover property (take_ins && dop == SP_EXTEND ##[1:4] take_ins && dchan);
	c_test_rupt: cover property (take_ins && dop == RUPT_GEN);
endmodule // instr_class_decode

// >>> verification/keypad_counter_model.sv
// Far-side model: keyboard unit pins and the priority counter request source.
// Assumes tasks are called just after a rising edge of core_clk.
`timescale 1ns/1ps
`include "instr_decode_defines.svh"
module keypad_counter_model
	import instr_decode_pkg::*;
(
	input  wire logic               core_clk,
	input  wire logic               counter_ack,
	output logic                    key_strobe_pin,
	output logic [`KEY_W-1:0]       keycode_pin,
	output logic                    counter_req,
	output logic [`CSEL_W-1:0]      counter_sel,
	output cnt_op_t                 counter_op
);
	int unsigned hold_cnt;

	initial begin
		key_strobe_pin = 1'b0;
		keycode_pin = 5'h1f;
		counter_req = 1'b0;
		counter_sel = 5'h00;
		counter_op = CNT_ONES_INC;
		hold_cnt = 0;
	end

	////////////////////////////////////////////////////////////////
	// Key held six cycles; code flips once released so stale data shows
	always @(posedge core_clk) begin
		if (key_strobe_pin) begin
			if (hold_cnt == 5) begin
				key_strobe_pin <= 1'b0;
				keycode_pin <= ~keycode_pin;
				hold_cnt <= 0;
			end else begin
				hold_cnt <= hold_cnt + 1;
			end
		end
	end

	// Waits out any earlier key; code settles two cycles ahead of the strobe
	task automatic press(input logic [`KEY_W-1:0] code);
		while (key_strobe_pin) begin
			@(posedge core_clk);
		end
		keycode_pin <= code;
		repeat (2) @(posedge core_clk);
		key_strobe_pin <= 1'b1;
	endtask

	// Request held until acknowledged, then fields scrambled
	task automatic count(input logic [`CSEL_W-1:0] sel, input cnt_op_t op);
		int n;
		n = 0;
		counter_req <= 1'b1;
		counter_sel <= sel;
		counter_op <= op;
		@(negedge core_clk);
		while (counter_ack !== 1'b1 && n < 20) begin
			@(negedge core_clk);
			n++;
		end
		@(posedge core_clk);
		counter_req <= 1'b0;
		counter_sel <= ~sel;
		counter_op <= cnt_op_t'(~op);
	endtask
endmodule // keypad_counter_model

// >>> verification/tb_instr_class_decode.sv
// Self-checking bench for the instruction classifier.
// Assumes the classifier alone; far side comes from keypad_counter_model.
`timescale 1ns/1ps
`include "instr_decode_defines.svh"
module tb_instr_class_decode
	import instr_decode_pkg::*;
;
	logic                  core_clk, rst, instr_valid, instr_ready, counter_req, counter_ack;
	logic [`WORD_W-1:0]    instr_word;
	logic [`CSEL_W-1:0]    counter_sel;
	cnt_op_t               counter_op;
	logic                  rupt_req, key_strobe_pin, monitor_stop_pin, disp_valid, disp_ready;
	logic [`KEY_W-1:0]     keycode_pin, key_channel;
	class_t                disp_class;
	op_t                   disp_op;
	logic [`ADDR_W-1:0]    disp_addr;
	logic                  disp_chan_space, disp_double, extend_mode, inhibit_mode;
	logic                  rupt_active, key_signal, monitor_stop;
	int                    err_count, tests_run, cycles;

	localparam logic [15:0] W [33] = '{
		16'h0123, 16'h1123, 16'h2123, 16'h3123, 16'h4123, 16'h4523, 16'h4823, 16'h5123,
		16'h5523, 16'h6123, 16'h7123, 16'h0004, 16'h0003, 16'h0010, 16'h0011, 16'h0012,
		16'h0013, 16'h00ab, 16'h02ab, 16'h04ab, 16'h06ab, 16'h08ab, 16'h0aab, 16'h0cab,
		16'h1123, 16'h2123, 16'h3123, 16'h4123, 16'h4523, 16'h4923, 16'h5123, 16'h6123,
		16'h7123};
	localparam op_t O [33] = '{
		TRANSFER, DECIDE, MODIFY, COPY, EXCHANGE, EXCHANGE_DBL, STORE, ADD_STORE,
		ADD_STORE_DBL, ADD, AND_OP, SP_INHIBIT, SP_RELEASE, SP_SHIFT_R, SP_ROT_R, SP_SHIFT_L,
		SP_ROT_L, CH_READ, CH_READ_AND, CH_READ_OR, CH_READ_XOR, CH_WRITE, CH_WRITE_AND,
		CH_WRITE_OR, DIV, SUB_TWOS, COPY_DBL, INC_SIGNED, INC_MAG, DEC_MAG, SUB, MUL, BRANCH};

	instr_class_decode dut (.core_clk(core_clk), .rst(rst), .instr_valid(instr_valid),
		.instr_ready(instr_ready), .instr_word(instr_word), .counter_req(counter_req),
		.counter_sel(counter_sel), .counter_op(counter_op), .counter_ack(counter_ack),
		.rupt_req(rupt_req), .key_strobe_pin(key_strobe_pin), .keycode_pin(keycode_pin),
		.monitor_stop_pin(monitor_stop_pin), .disp_valid(disp_valid), .disp_ready(disp_ready),
		.disp_class(disp_class), .disp_op(disp_op), .disp_addr(disp_addr),
		.disp_chan_space(disp_chan_space), .disp_double(disp_double),
		.extend_mode(extend_mode), .inhibit_mode(inhibit_mode), .rupt_active(rupt_active),
		.key_channel(key_channel), .key_signal(key_signal), .monitor_stop(monitor_stop));

	keypad_counter_model fp (.core_clk(core_clk), .counter_ack(counter_ack),
		.key_strobe_pin(key_strobe_pin), .keycode_pin(keycode_pin),
		.counter_req(counter_req), .counter_sel(counter_sel), .counter_op(counter_op));

	always #4 core_clk = ~core_clk;

	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 5000) begin
			err_count++;
			end_sim();
		end
	end

	////////////////////////////////////////////////////////////////
	task automatic end_sim();
		if (err_count == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	task automatic issue(input logic [15:0] w);
		int n;
		n = 0;
		@(posedge core_clk);
		instr_valid <= 1'b1;
		instr_word <= w;
		@(negedge core_clk);
		while (instr_ready !== 1'b1 && n < 20) begin
			@(negedge core_clk);
			n++;
		end
		@(posedge core_clk);
		instr_valid <= 1'b0;
		instr_word <= ~w;
	endtask

	// Bounded wait for a dispatch, then compare its fields
	task automatic expect_disp(input class_t c, input op_t o, input logic [11:0] a);
		int n;
		n = 0;
		@(negedge core_clk);
		while (disp_valid !== 1'b1 && n < 20) begin
			@(negedge core_clk);
			n++;
		end
		check(disp_valid, 1'b1);
		check(disp_class, c);
		check(disp_op, o);
		check(disp_addr, a);
	endtask

	task automatic wait_key();
		int n;
		n = 0;
		while (key_signal !== 1'b1 && n < 10) begin
			@(negedge core_clk);
			n++;
		end
		check(key_signal, 1'b1);
	endtask

	task automatic resume();
		issue(`SPC_RESUME);
		expect_disp(CL_SPECIAL, SP_RESUME, `SPC_RESUME);
	endtask

	////////////////////////////////////////////////////////////////
	task automatic t_table();
		class_t c;
		for (int i = 0; i < 33; i++) begin
			c = (i < 11) ? CL_BASIC : (i < 17) ? CL_SPECIAL : (i < 24) ? CL_CHANNEL : CL_EXTRA;
			if (i >= 17) begin
				issue(`SPC_EXTEND);
				expect_disp(CL_SPECIAL, SP_EXTEND, `SPC_EXTEND);
				check(extend_mode, 1'b1);
			end
			issue(W[i]);
			expect_disp(c, O[i], (c == CL_CHANNEL) ? {3'h0, W[i][8:0]} : W[i][11:0]);
			check(disp_chan_space, c == CL_CHANNEL);
			check(disp_double, O[i] inside {COPY_DBL, EXCHANGE_DBL, ADD_STORE_DBL, MUL, DIV});
			check(extend_mode, 1'b0);
			if (i == 11) check(inhibit_mode, 1'b1);
		end
	endtask

	// Slot held while the sequencer stalls
	task automatic t_stall();
		// Let the last table dispatch drain before stalling the slot
		@(posedge core_clk);
		disp_ready <= 1'b0;
		issue(16'h6123);
		expect_disp(CL_BASIC, ADD, 12'h123);
		repeat (3) begin
			@(negedge core_clk);
			check(disp_valid, 1'b1);
			check(instr_ready, 1'b0);
		end
		@(posedge core_clk);
		disp_ready <= 1'b1;
		// Slot stands until the edge that sees ready high
		@(negedge core_clk);
		check(disp_valid, 1'b1);
		@(negedge core_clk);
		check(disp_valid, 1'b0);
	endtask

	task automatic t_key();
		@(posedge core_clk);
		fp.press(5'h0b);
		wait_key();
		check(key_channel, 5'h0b);
		expect_disp(CL_INTERRUPT, RUPT_KEY, `KEY_VEC);
		check(rupt_active, 1'b1);
		@(posedge core_clk);
		fp.press(5'h15);
		wait_key();
		check(key_channel, 5'h15);
		repeat (6) begin
			@(negedge core_clk);
			check(disp_valid, 1'b0);
		end
		resume();
		expect_disp(CL_INTERRUPT, RUPT_KEY, `KEY_VEC);
		resume();
	endtask

	task automatic t_rupt();
		issue(`SPC_TESTRUPT);
		expect_disp(CL_INTERRUPT, RUPT_GEN, `RUPT_VEC);
		check(rupt_active, 1'b1);
		resume();
		issue(`SPC_INHINT);
		expect_disp(CL_SPECIAL, SP_INHIBIT, `SPC_INHINT);
		@(posedge core_clk);
		rupt_req <= 1'b1;
		repeat (4) begin
			@(negedge core_clk);
			check(disp_valid, 1'b0);
		end
		issue(`SPC_RELINT);
		expect_disp(CL_SPECIAL, SP_RELEASE, `SPC_RELINT);
		expect_disp(CL_INTERRUPT, RUPT_GEN, `RUPT_VEC);
		@(posedge core_clk);
		rupt_req <= 1'b0;
		resume();
	endtask

	task automatic cnt_case(input logic [4:0] sel, input cnt_op_t op, input op_t o);
		@(posedge core_clk);
		fp.count(sel, op);
		expect_disp(CL_COUNTER, o, `CNT_BASE + {7'h00, sel});
	endtask

	task automatic t_counter();
		@(posedge core_clk);
		instr_valid <= 1'b1;
		instr_word <= 16'h6123;
		fp.count(5'h00, CNT_ONES_INC);
		expect_disp(CL_COUNTER, CNT_INC1, `CNT_BASE);
		@(posedge core_clk);
		instr_valid <= 1'b0;
		expect_disp(CL_BASIC, ADD, 12'h123);
		cnt_case(5'h07, CNT_ONES_DEC, CNT_DEC1);
		cnt_case(5'h0c, CNT_TWOS_INC, CNT_INC2);
		@(posedge core_clk);
		fp.count(5'h1d, CNT_ONES_INC);
		repeat (3) begin
			@(negedge core_clk);
			check(disp_valid, 1'b0);
		end
	endtask

	task automatic t_monitor();
		int n;
		n = 0;
		@(posedge core_clk);
		monitor_stop_pin <= 1'b1;
		while (monitor_stop !== 1'b1 && n < 8) begin
			@(negedge core_clk);
			n++;
		end
		check(monitor_stop, 1'b1);
		check(instr_ready, 1'b0);
		cnt_case(5'h1c, CNT_TWOS_DEC, CNT_DEC2);
		@(posedge core_clk);
		monitor_stop_pin <= 1'b0;
		repeat (5) @(posedge core_clk);
		@(negedge core_clk);
		check(monitor_stop, 1'b0);
		check(instr_ready, 1'b1);
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		core_clk = 1'b0;
		rst = 1'b1;
		instr_valid = 1'b0;
		instr_word = 16'h0000;
		rupt_req = 1'b0;
		monitor_stop_pin = 1'b0;
		disp_ready = 1'b1;
		err_count = 0;
		tests_run = 0;
		cycles = 0;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		@(negedge core_clk);
		check(disp_valid, 1'b0);
		check(instr_ready, 1'b1);
		check($bits(dut.instr_word), 16'h0010);
		t_table();
		t_stall();
		t_key();
		t_rupt();
		t_counter();
		t_monitor();
		end_sim();
	end
endmodule // tb_instr_class_decode
